// ==== hw/ddl_pkg.sv ====
// Shared constants and types for the converter datapath latency block.
package ddl_pkg;
    localparam int DDL_CLK_MHZ = 125;
    localparam logic [11:0] DDL_PD_ADDR = 12'h011;
    localparam logic [7:0] DDL_PD_RESET = 8'h78;
    localparam logic [7:0] DDL_PD_PAIR_A = 8'h60;
    localparam logic [7:0] DDL_PD_PAIR_B = 8'h18;
    localparam int DDL_PU_TIME_US = 30;
    localparam int DDL_PU_CYCLES = DDL_PU_TIME_US * DDL_CLK_MHZ;
    localparam int DDL_PU_W = 12;
    localparam logic [5:0] DDL_LANE_PER_PCLK = 6'h28;
    localparam int DDL_LAT_IF = 17;
    localparam logic [9:0] DDL_LAT_INT1 = 10'h05E;
    localparam logic [9:0] DDL_LAT_INT2 = 10'h082;
    localparam logic [9:0] DDL_LAT_INT4 = 10'h0FA;
    localparam logic [9:0] DDL_LAT_INT8 = 10'h1DA;
    localparam logic [9:0] DDL_LAT_INVSINC = 10'h011;
    localparam logic [9:0] DDL_LAT_FINE = 10'h014;
    localparam logic [9:0] DDL_LAT_CRS8 = 10'h008;
    localparam logic [9:0] DDL_LAT_CRS4 = 10'h004;
    localparam logic [9:0] DDL_LAT_PHASE = 10'h00C;
    localparam logic [9:0] DDL_LAT_GAIN = 10'h00C;
    localparam logic [2:0] DDL_SYSREF_LMFC = 3'h4;
    localparam int DDL_RING_AW = 10;
    typedef enum logic [1:0] {
        DDL_INT_1X = 2'b00,
        DDL_INT_2X = 2'b01,
        DDL_INT_4X = 2'b10,
        DDL_INT_8X = 2'b11
    } ddl_interp_t;
    typedef enum logic [1:0] {
        DDL_CRS_OFF = 2'b00,
        DDL_CRS_FS8 = 2'b01,
        DDL_CRS_FS4 = 2'b10
    } ddl_coarse_t;
endpackage

// ==== hw/ddl_pair_timer.sv ====
// Power-up timer for one converter pair.
`timescale 1ns/1ps
module ddl_pair_timer
    import ddl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic powered_down,
    output logic ready
);
    logic [DDL_PU_W-1:0] cnt;

    // Counts the settling time once the pair leaves power-down.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt <= 12'h000;
            ready <= 1'b0;
        end else if (powered_down) begin
            cnt <= 12'h000;
            ready <= 1'b0;
        end else if (!ready) begin
            if (cnt == DDL_PU_W'(DDL_PU_CYCLES - 1)) begin
                ready <= 1'b1;
            end else begin
                cnt <= cnt + 12'h001;
            end
        end
    end

    property p_ready_time;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(ready) |-> $past(cnt) == DDL_PU_W'(DDL_PU_CYCLES - 1) && !$past(powered_down);
    endproperty
    a_ready_time: assert property (p_ready_time) else $error("Pair ready before settling time.");

    property p_down_clears;
        @(posedge clk_sys) disable iff (!resetn)
        powered_down |=> !ready;
    endproperty
    a_down_clears: assert property (p_down_clears) else $error("Pair ready while powered down.");
endmodule

// ==== hw/ddl_core.sv ====
// Transmit datapath latency model with power-up timing and link timing reference alignment.
//
// Function
// - Link logic runs at lane rate over 40.
// - Interpolation adds 94, 130, 250, 474 cycles.
// - Inverse sinc adds 17 sample cycles.
// - Fine modulation adds 20 sample cycles.
// - Phase and gain adjust add 12 each.
// - First pair ready 30 us after clear.
// - Second pair ready 30 us after clear.
// - All converters ready 30 us after clear.
// - Multiframe edge 4 sample cycles after reference.
// - Timing reference aligns multiframe clock, subclass 1.
`timescale 1ns/1ps
module ddl_core
    import ddl_pkg::*;
#(
    parameter int DW = 16,
    parameter int LANE_DIV = 1,
    parameter int SAMP_DIV = 1,
    parameter int LMFC_PERIOD = 32
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] interp_mode,
    input wire logic inv_sinc_en,
    input wire logic fine_mod_en,
    input wire logic [1:0] coarse_mode,
    input wire logic phase_adj_en,
    input wire logic gain_adj_en,
    input wire logic [DW-1:0] link_data,
    input wire logic link_timing_ref,
    output logic [DW-1:0] dac_data,
    output logic dac_valid,
    output logic [9:0] stage_latency,
    output logic [1:0] pair_ready,
    output logic lmfc_edge,
    output logic link_sync_request_output_n
);
    logic [7:0] converter_power_down;
    logic [15:0] lane_div_cnt;
    logic [15:0] samp_div_cnt;
    logic lane_tick;
    logic samp_tick;
    logic [5:0] pclk_cnt;
    logic lane_processing_clock;
    logic [DW-1:0] if_pipe [0:DDL_LAT_IF-1];
    logic [DW-1:0] ring [0:(1<<DDL_RING_AW)-1];
    logic [DDL_RING_AW-1:0] wr_ptr;
    logic [9:0] next_stage_latency;
    logic [9:0] fill_cnt;
    logic [2:0] ref_sync;
    logic ref_level;
    logic ref_edge;
    logic [2:0] align_cnt;
    logic [15:0] lmfc_cnt;
    logic aligned;

    // Register port for the power-down control.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            converter_power_down <= DDL_PD_RESET;
        end else if (reg_wr && reg_addr == DDL_PD_ADDR) begin
            converter_power_down <= reg_wdata;
        end
    end

    always_comb begin
        reg_rdata = (reg_addr == DDL_PD_ADDR) ? converter_power_down : 8'h00;
    end

    ddl_pair_timer u_pair_a (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .powered_down(|(converter_power_down & DDL_PD_PAIR_A)),
        .ready(pair_ready[0])
    );

    ddl_pair_timer u_pair_b (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .powered_down(|(converter_power_down & DDL_PD_PAIR_B)),
        .ready(pair_ready[1])
    );

    // Lane bit and sample rate enables.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lane_div_cnt <= 16'h0000;
            samp_div_cnt <= 16'h0000;
        end else begin
            lane_div_cnt <= lane_tick ? 16'h0000 : lane_div_cnt + 16'h0001;
            samp_div_cnt <= samp_tick ? 16'h0000 : samp_div_cnt + 16'h0001;
        end
    end

    assign lane_tick = (lane_div_cnt == 16'(LANE_DIV - 1));
    assign samp_tick = (samp_div_cnt == 16'(SAMP_DIV - 1));

    // Processing clock enable once every 40 lane bit times.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pclk_cnt <= 6'h00;
        end else if (lane_tick) begin
            pclk_cnt <= lane_processing_clock ? 6'h00 : pclk_cnt + 6'h01;
        end
    end

    assign lane_processing_clock = lane_tick && (pclk_cnt == DDL_LANE_PER_PCLK - 6'h01);

    // Link interface delay in processing clock cycles.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DDL_LAT_IF; i++) begin
                if_pipe[i] <= '0;
            end
        end else if (lane_processing_clock) begin
            if_pipe[0] <= link_data;
            for (int i = 1; i < DDL_LAT_IF; i++) begin
                if_pipe[i] <= if_pipe[i-1];
            end
        end
    end

    // Sum of enabled sample-clock stages; bypassed stages add nothing.
    always_comb begin
        next_stage_latency = 10'h000;
        unique case (ddl_interp_t'(interp_mode))
            DDL_INT_1X: next_stage_latency = DDL_LAT_INT1;
            DDL_INT_2X: next_stage_latency = DDL_LAT_INT2;
            DDL_INT_4X: next_stage_latency = DDL_LAT_INT4;
            DDL_INT_8X: next_stage_latency = DDL_LAT_INT8;
        endcase
        if (inv_sinc_en) begin
            next_stage_latency = next_stage_latency + DDL_LAT_INVSINC;
        end
        if (fine_mod_en) begin
            next_stage_latency = next_stage_latency + DDL_LAT_FINE;
        end
        if (coarse_mode == DDL_CRS_FS8) begin
            next_stage_latency = next_stage_latency + DDL_LAT_CRS8;
        end else if (coarse_mode == DDL_CRS_FS4) begin
            next_stage_latency = next_stage_latency + DDL_LAT_CRS4;
        end
        if (phase_adj_en) begin
            next_stage_latency = next_stage_latency + DDL_LAT_PHASE;
        end
        if (gain_adj_en) begin
            next_stage_latency = next_stage_latency + DDL_LAT_GAIN;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage_latency <= DDL_LAT_INT1;
        end else begin
            stage_latency <= next_stage_latency;
        end
    end

    // Sample-clock delay line as a ring; read trails write by the stage latency.
    always_ff @(posedge clk_sys) begin
        if (samp_tick) begin
            ring[wr_ptr] <= if_pipe[DDL_LAT_IF-1];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            fill_cnt <= 10'h000;
            dac_data <= '0;
            dac_valid <= 1'b0;
        end else if (samp_tick) begin
            wr_ptr <= wr_ptr + 10'h001;
            if (fill_cnt != 10'h3FF) begin
                fill_cnt <= fill_cnt + 10'h001;
            end
            dac_data <= ring[wr_ptr - stage_latency];
            dac_valid <= fill_cnt >= stage_latency && (|pair_ready);
        end
    end

    // Timing reference pin synchroniser and edge detect.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_sync <= 3'h0;
            ref_level <= 1'b0;
        end else begin
            ref_sync <= {ref_sync[1:0], link_timing_ref};
            if (ref_sync[1] == ref_sync[2]) begin
                ref_level <= ref_sync[2];
            end
        end
    end

    assign ref_edge = (ref_sync[1] == ref_sync[2]) && ref_sync[2] && !ref_level;

    // Multiframe clock, realigned a fixed count of sample cycles after the reference.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            align_cnt <= 3'h0;
            lmfc_cnt <= 16'h0000;
            lmfc_edge <= 1'b0;
            aligned <= 1'b0;
        end else begin
            lmfc_edge <= 1'b0;
            if (ref_edge) begin
                align_cnt <= DDL_SYSREF_LMFC;
            end else if (samp_tick && align_cnt != 3'h0) begin
                align_cnt <= align_cnt - 3'h1;
            end
            if (samp_tick) begin
                if (align_cnt == 3'h1 && !ref_edge) begin
                    lmfc_cnt <= 16'h0000;
                    lmfc_edge <= 1'b1;
                    aligned <= 1'b1;
                end else if (lmfc_cnt == 16'(LMFC_PERIOD - 1)) begin
                    lmfc_cnt <= 16'h0000;
                    lmfc_edge <= 1'b1;
                end else begin
                    lmfc_cnt <= lmfc_cnt + 16'h0001;
                end
            end
        end
    end

    // Sync request held while not aligned or all converters down.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            link_sync_request_output_n <= 1'b0;
        end else begin
            link_sync_request_output_n <= aligned && (|pair_ready);
        end
    end

    // Helper: lane ticks since the last processing clock enable.
    logic [5:0] pclk_gap;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pclk_gap <= 6'h00;
        end else if (lane_processing_clock) begin
            pclk_gap <= 6'h00;
        end else if (lane_tick) begin
            pclk_gap <= pclk_gap + 6'h01;
        end
    end

    // Helper: sample ticks since the last reference edge.
    logic [3:0] ref_age;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_age <= 4'hF;
        end else if (ref_edge) begin
            ref_age <= 4'h0;
        end else if (samp_tick && ref_age != 4'hF) begin
            ref_age <= ref_age + 4'h1;
        end
    end

    sequence s_only_sinc_rises;
        $rose(inv_sinc_en) && $stable(interp_mode) && $stable(fine_mod_en) && $stable(coarse_mode)
            && $stable(phase_adj_en) && $stable(gain_adj_en);
    endsequence

    property p_pclk;
        @(posedge clk_sys) disable iff (!resetn)
        lane_processing_clock |-> pclk_gap == DDL_LANE_PER_PCLK - 6'h01;
    endproperty
    a_pclk: assert property (p_pclk) else $error("Processing clock not at lane over 40.");

    property p_interp;
        @(posedge clk_sys) disable iff (!resetn)
        (interp_mode == 2'b11 && !inv_sinc_en && !fine_mod_en && coarse_mode == 2'b00
            && !phase_adj_en && !gain_adj_en) |=> stage_latency == 10'h1DA;
    endproperty
    a_interp: assert property (p_interp) else $error("8x interpolation latency wrong.");

    property p_sinc;
        @(posedge clk_sys) disable iff (!resetn)
        s_only_sinc_rises |=> stage_latency == $past(stage_latency) + 10'h011;
    endproperty
    a_sinc: assert property (p_sinc) else $error("Inverse sinc latency wrong.");

    property p_fine;
        @(posedge clk_sys) disable iff (!resetn)
        ($rose(fine_mod_en) && $stable(interp_mode) && $stable(inv_sinc_en) && $stable(coarse_mode)
            && $stable(phase_adj_en) && $stable(gain_adj_en)) |=> stage_latency == $past(stage_latency) + 10'h014;
    endproperty
    a_fine: assert property (p_fine) else $error("Fine modulation latency wrong.");

    property p_phase_gain;
        @(posedge clk_sys) disable iff (!resetn)
        (interp_mode == 2'b00 && !inv_sinc_en && !fine_mod_en && coarse_mode == 2'b00
            && phase_adj_en && gain_adj_en) |=> stage_latency == 10'h076;
    endproperty
    a_phase_gain: assert property (p_phase_gain) else $error("Phase and gain latency wrong.");

    property p_all_ready;
        @(posedge clk_sys) disable iff (!resetn)
        (pair_ready == 2'b11) |-> ($past(converter_power_down) & 8'h78) == 8'h00;
    endproperty
    a_all_ready: assert property (p_all_ready) else $error("Converters ready while powered down.");

    property p_lmfc_delay;
        @(posedge clk_sys) disable iff (!resetn)
        ($rose(aligned) || (lmfc_edge && $past(align_cnt) == 3'h1 && $past(samp_tick) && !$past(ref_edge)))
            |-> ref_age == 4'h4;
    endproperty
    a_lmfc_delay: assert property (p_lmfc_delay) else $error("Multiframe edge not 4 samples after reference.");

    property p_sync;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(link_sync_request_output_n) |-> $past(aligned) && $past(pair_ready) != 2'b00;
    endproperty
    a_sync: assert property (p_sync) else $error("Sync released before alignment.");

    property p_bypass;
        @(posedge clk_sys) disable iff (!resetn)
        (interp_mode == 2'b00 && !inv_sinc_en && !fine_mod_en && coarse_mode == 2'b00
            && !phase_adj_en && !gain_adj_en) |=> stage_latency == 10'h05E;
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypassed stages added latency.");
endmodule

// ==== sim/ddl_tx_model.sv ====
// Link transmitter model that feeds sample words and the timing reference.
`timescale 1ns/1ps
module ddl_tx_model
    import ddl_pkg::*;
#(
    parameter int DW = 16
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [DW-1:0] word_in,
    input wire logic ref_req,
    output logic [DW-1:0] link_data,
    output logic link_timing_ref
);
    logic [5:0] beat;
    logic [3:0] ref_hold;
    // Words change once per processing period of 40 lane ticks.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            beat <= 6'h00;
            link_data <= '0;
        end else begin
            beat <= (beat == DDL_LANE_PER_PCLK - 6'h01) ? 6'h00 : beat + 6'h01;
            if (beat == 6'h00) begin
                link_data <= word_in;
            end
        end
    end
    // Reference pulses last eight clocks so the synchroniser sees them.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_hold <= 4'h0;
        end else if (ref_req && ref_hold == 4'h0) begin
            ref_hold <= 4'h8;
        end else if (ref_hold != 4'h0) begin
            ref_hold <= ref_hold - 4'h1;
        end
    end
    assign link_timing_ref = (ref_hold != 4'h0);
endmodule

// ==== sim/test_dac_datapath_latency.sv ====
// Self-checking bench for the converter datapath latency block.
`timescale 1ns/1ps
module test_dac_datapath_latency;
    import ddl_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] interp_mode = 2'b00;
    logic inv_sinc_en = 1'b0;
    logic fine_mod_en = 1'b0;
    logic [1:0] coarse_mode = 2'b00;
    logic phase_adj_en = 1'b0;
    logic gain_adj_en = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic ref_req = 1'b0;
    logic [15:0] link_data;
    logic link_timing_ref;
    logic [15:0] dac_data;
    logic dac_valid;
    logic [9:0] stage_latency;
    logic [1:0] pair_ready;
    logic lmfc_edge;
    logic link_sync_request_output_n;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #4 clk_sys = ~clk_sys;

    ddl_tx_model #(.DW(16)) partner (.clk_sys(clk_sys), .resetn(resetn), .word_in(word_in),
        .ref_req(ref_req), .link_data(link_data), .link_timing_ref(link_timing_ref));

    ddl_core #(.DW(16), .LANE_DIV(1), .SAMP_DIV(1), .LMFC_PERIOD(32)) DUT (.clk_sys(clk_sys),
        .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .interp_mode(interp_mode), .inv_sinc_en(inv_sinc_en),
        .fine_mod_en(fine_mod_en), .coarse_mode(coarse_mode), .phase_adj_en(phase_adj_en),
        .gain_adj_en(gain_adj_en), .link_data(link_data), .link_timing_ref(link_timing_ref),
        .dac_data(dac_data), .dac_valid(dac_valid), .stage_latency(stage_latency),
        .pair_ready(pair_ready), .lmfc_edge(lmfc_edge),
        .link_sync_request_output_n(link_sync_request_output_n));

    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        reg_addr = DDL_PD_ADDR;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
    endtask

    task automatic reset_values();
        reg_addr = DDL_PD_ADDR;
        #1 check(reg_rdata, DDL_PD_RESET);
        reg_addr = 12'h012;
        #1 check(reg_rdata, 16'h0000);
        check(stage_latency, DDL_LAT_INT1);
        check(pair_ready, 16'h0000);
    endtask

    task automatic ref_alignment();
        int n;
        n = 0;
        ref_req = 1'b1;
        @(posedge clk_sys);
        #1 ref_req = 1'b0;
        while (lmfc_edge !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check(n >= 5 && n <= 10, 16'h0001);
        repeat (32) @(posedge clk_sys);
        #1 check(lmfc_edge, 16'h0001);
    endtask

    task automatic latency_table();
        logic [9:0] exp;
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 4; c++) begin
                for (int e = 0; e < 16; e++) begin
                    interp_mode = m[1:0];
                    coarse_mode = c[1:0];
                    {gain_adj_en, phase_adj_en, fine_mod_en, inv_sinc_en} = e[3:0];
                    exp = (m == 0) ? DDL_LAT_INT1 : (m == 1) ? DDL_LAT_INT2 :
                          (m == 2) ? DDL_LAT_INT4 : DDL_LAT_INT8;
                    exp += e[0] ? 10'h011 : 10'h000;
                    exp += e[1] ? 10'h014 : 10'h000;
                    exp += e[2] ? 10'h00C : 10'h000;
                    exp += e[3] ? 10'h00C : 10'h000;
                    exp += (c == 1) ? 10'h008 : (c == 2) ? 10'h004 : 10'h000;
                    @(posedge clk_sys);
                    #1 check(stage_latency, exp);
                end
            end
        end
        {interp_mode, coarse_mode, gain_adj_en, phase_adj_en, fine_mod_en, inv_sinc_en} = 8'h00;
        @(posedge clk_sys);
        #1 fine_mod_en = 1'b1;
        @(posedge clk_sys);
        #1 check(stage_latency, DDL_LAT_INT1 + DDL_LAT_FINE);
        fine_mod_en = 1'b0;
    endtask

    task automatic power_up(input logic [7:0] d, input logic [1:0] keep);
        wr(d);
        reg_addr = DDL_PD_ADDR;
        #1 check(reg_rdata, d);
        @(posedge clk_sys);
        #1 check(pair_ready, keep);
        wr(8'h00);
        repeat (3749) @(posedge clk_sys);
        #1 check(pair_ready, keep);
        repeat (2) @(posedge clk_sys);
        #1 check(pair_ready, 16'h0003);
    endtask

    task automatic sample_path();
        int n;
        n = 0;
        word_in = 16'hA5C3;
        repeat (1500) @(posedge clk_sys);
        #1 check(dac_valid, 16'h0001);
        check(dac_data, 16'hA5C3);
        word_in = 16'h3C5A;
        while (dac_data !== 16'h3C5A && n < 2000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check(n > 94 && n <= 900, 16'h0001);
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        #1 resetn = 1'b1;
        reset_values();
        ref_alignment();
        check(link_sync_request_output_n, 16'h0000);
        latency_table();
        power_up(8'h78, 2'b00);
        power_up(8'h60, 2'b10);
        power_up(8'h18, 2'b01);
        check(link_sync_request_output_n, 16'h0001);
        sample_path();
        report_and_stop();
    end
endmodule
